// *** common/sat_pkg.sv ***
// Package with register numbers, entry layout and timing constants of the address table access.
package sat_pkg;
  // ----------------------------------------------------------------
  // Register numbers
  // ----------------------------------------------------------------
  localparam logic [15:0] REG_CMD     = 16'h1800;
  localparam logic [15:0] REG_WR0     = 16'h1801;
  localparam logic [15:0] REG_WR1     = 16'h1802;
  localparam logic [15:0] REG_RD0     = 16'h1805;
  localparam logic [15:0] REG_RD1     = 16'h1806;
  localparam logic [15:0] REG_CMD_STS = 16'h1808;

  // ----------------------------------------------------------------
  // Field positions and widths
  // ----------------------------------------------------------------
  localparam int CMD_NEXT_BIT  = 0;
  localparam int CMD_FIRST_BIT = 1;
  localparam int CMD_MAKE_BIT  = 2;
  localparam int STS_MAKE_BIT  = 0;
  localparam int STS_READ_BIT  = 1;
  localparam int WR1_W         = 25;
  localparam int ENT_W         = 32 + WR1_W;
  localparam int MAC_W         = 48;
  localparam int PORT_W        = 3;
  localparam int ENT_VALID     = 32 + 24;
  localparam int ENT_AGE       = 32 + 23;
  localparam int ENT_STATIC    = 32 + 22;
  localparam int ENT_PORT_LO   = 32 + 16;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [31:0] WR0_RESET     = 32'h0000_0000;
  localparam logic [WR1_W-1:0] WR1_RESET = 25'h000_0000;
  localparam longint CLK_HZ             = 125_000_000;
  localparam longint AGE_PERIOD_S       = 300;
  localparam longint AGE_CYCLES         = AGE_PERIOD_S * CLK_HZ;
  localparam int     AGE_CNT_W          = 40;
  localparam int     TABLE_DEPTH        = 64;
endpackage

// *** common/sat_tbl_if.sv ***
// Interface between the register front end and the address table store.
interface sat_tbl_if;
  logic                         mk_req;
  logic [sat_pkg::ENT_W-1:0]    mk_entry;
  logic                         mk_done;
  logic                         rd_req;
  logic                         rd_first;
  logic                         rd_done;
  logic [sat_pkg::ENT_W-1:0]    rd_entry;
  logic                         ln_valid;
  logic [sat_pkg::MAC_W-1:0]    ln_mac;
  logic [sat_pkg::PORT_W-1:0]   ln_port;

  modport ctl (output mk_req, mk_entry, rd_req, rd_first, ln_valid, ln_mac, ln_port,
               input mk_done, rd_done, rd_entry);
  modport tbl (input mk_req, mk_entry, rd_req, rd_first, ln_valid, ln_mac, ln_port,
               output mk_done, rd_done, rd_entry);
endinterface : sat_tbl_if

// *** rtl/sat_table.sv ***
// Address table store with make, walk, learning and aging.
module sat_table #(
  parameter int     DEPTH      = sat_pkg::TABLE_DEPTH,
  parameter longint AGE_CYCLES = sat_pkg::AGE_CYCLES
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic nrst,
  // Table port.
  sat_tbl_if.tbl   tb
);
  localparam int IW = $clog2(DEPTH);

  logic [sat_pkg::ENT_W-1:0]     ent_q [DEPTH];
  logic [IW:0]                   rd_ptr_q;
  logic                          mk_done_q;
  logic                          rd_done_q;
  logic [sat_pkg::ENT_W-1:0]     rd_entry_q;
  logic [sat_pkg::AGE_CNT_W-1:0] age_cnt_q;
  logic [DEPTH-1:0]              vld_w;
  logic [DEPTH-1:0]              mk_hit_w;
  logic [DEPTH-1:0]              ln_hit_w;

  // ----------------------------------------------------------------
  // Search helpers
  // ----------------------------------------------------------------
  // Lowest set bit at or above start; result is {found, index}.
  function automatic logic [IW:0] first_set(input logic [DEPTH-1:0] vec,
                                            input logic [IW:0] start);
    logic [IW:0] res;
    res = '0;
    for (int i = DEPTH - 1; i >= 0; i--) begin
      if (vec[i] && (i >= int'(start))) begin
        res = {1'b1, IW'(i)};
      end
    end
    return res;
  endfunction

  // Per entry valid and address-match vectors.
  for (genvar i = 0; i < DEPTH; i++) begin : g_cmp
    assign vld_w[i]    = ent_q[i][sat_pkg::ENT_VALID];
    assign mk_hit_w[i] = vld_w[i] && (ent_q[i][sat_pkg::MAC_W-1:0] ==
                                      tb.mk_entry[sat_pkg::MAC_W-1:0]);
    assign ln_hit_w[i] = vld_w[i] && (ent_q[i][sat_pkg::MAC_W-1:0] == tb.ln_mac);
  end

  // Location choice: a matching entry is reused, otherwise the first free slot.
  wire logic [IW:0] free_w   = first_set(~vld_w, '0);
  wire logic [IW:0] mk_hit   = first_set(mk_hit_w, '0);
  wire logic [IW:0] ln_hit   = first_set(ln_hit_w, '0);
  wire logic [IW-1:0] mk_idx = mk_hit[IW] ? mk_hit[IW-1:0] : free_w[IW-1:0];
  wire logic mk_ok = mk_hit[IW] || (free_w[IW] && tb.mk_entry[sat_pkg::ENT_VALID]);
  wire logic [IW-1:0] ln_idx = ln_hit[IW] ? ln_hit[IW-1:0] : free_w[IW-1:0];
  wire logic ln_ok = tb.ln_valid && (ln_hit[IW] ?
                     !ent_q[ln_idx][sat_pkg::ENT_STATIC] : free_w[IW]);
  wire logic [IW:0] rd_start = tb.rd_first ? '0 : rd_ptr_q;
  wire logic [IW:0] rd_res   = first_set(vld_w, rd_start);
  wire logic age_tick = (age_cnt_q == sat_pkg::AGE_CNT_W'(AGE_CYCLES - 1));
  wire logic [sat_pkg::ENT_W-1:0] ln_new = {3'b110, 3'b000,
                                            tb.ln_port, tb.ln_mac};

  assign tb.mk_done  = mk_done_q;
  assign tb.rd_done  = rd_done_q;
  assign tb.rd_entry = rd_entry_q;

  // ----------------------------------------------------------------
  // Entry storage
  // ----------------------------------------------------------------
  // Make outranks learning; a learning event lost to a make is simply seen again later.
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < DEPTH; i++) begin
      if (!nrst) begin
        ent_q[i] <= '0;
      end else if (tb.mk_req && mk_ok && (IW'(i) == mk_idx)) begin
        ent_q[i] <= tb.mk_entry;
      end else if (!tb.mk_req && ln_ok && (IW'(i) == ln_idx)) begin
        ent_q[i] <= ln_hit[IW] ? {ent_q[i][sat_pkg::ENT_W-1:sat_pkg::ENT_PORT_LO+3],
                                  tb.ln_port, tb.ln_mac} | (57'h1 << sat_pkg::ENT_AGE)
                               : ln_new;
      end else if (age_tick && vld_w[i] && !ent_q[i][sat_pkg::ENT_STATIC]) begin
        ent_q[i][sat_pkg::ENT_AGE]   <= 1'b0;
        ent_q[i][sat_pkg::ENT_VALID] <= ent_q[i][sat_pkg::ENT_AGE];
      end
    end
  end

  // Aging period counter; an idle learned entry goes after one to two periods, a static entry never goes.
  always_ff @(posedge core_clk) begin
    if (!nrst || age_tick) begin
      age_cnt_q <= '0;
    end else begin
      age_cnt_q <= age_cnt_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Command answers
  // ----------------------------------------------------------------
  // A walk past the last valid entry returns an all-zero entry and parks the pointer.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      mk_done_q  <= 1'b0;
      rd_done_q  <= 1'b0;
      rd_entry_q <= '0;
      rd_ptr_q   <= '0;
    end else begin
      mk_done_q <= tb.mk_req;
      rd_done_q <= tb.rd_req;
      if (tb.rd_req) begin
        rd_entry_q <= rd_res[IW] ? ent_q[rd_res[IW-1:0]] : '0;
        rd_ptr_q   <= rd_res[IW] ? (IW+1)'(rd_res[IW-1:0]) + 1'b1 : (IW+1)'(DEPTH);
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  AST_MAKE_HIT_WRITE: assert property (tb.mk_req && mk_hit[IW] |=>
    ent_q[$past(mk_hit[IW-1:0])] == $past(tb.mk_entry))
    else $error("Make did not overwrite the matching entry.");
  AST_MAKE_DELETE: assert property (tb.mk_req && mk_hit[IW] &&
    !tb.mk_entry[sat_pkg::ENT_VALID] |=> !vld_w[$past(mk_hit[IW-1:0])])
    else $error("Make with valid clear did not remove the entry.");
  AST_STATIC_KEEP: assert property (age_tick && !tb.mk_req && vld_w[0] &&
    ent_q[0][sat_pkg::ENT_STATIC] |=> vld_w[0])
    else $error("Static entry was aged out.");
endmodule : sat_table

// *** rtl/sat_top.sv ***
// Register front end for manual access to the switch address table.

module sat_top #(
  parameter int     DEPTH      = sat_pkg::TABLE_DEPTH,
  parameter longint AGE_CYCLES = sat_pkg::AGE_CYCLES
) (
  // Clock and reset.
  input  wire logic                       core_clk,
  input  wire logic                       nrst,
  // Register port.
  input  wire logic [15:0]                csr_addr,
  input  wire logic                       csr_wr,
  input  wire logic                       csr_rd,
  input  wire logic [31:0]                csr_wdata,
  output logic [31:0]                     csr_rdata,
  output logic                            csr_ack,
  // Learning events from the forwarding path.
  input  wire logic                       learn_valid,
  input  wire logic [sat_pkg::MAC_W-1:0]  learn_mac,
  input  wire logic [sat_pkg::PORT_W-1:0] learn_port
);
  logic [2:0]                    cmd_q;
  logic [31:0]                   wr0_q;
  logic [sat_pkg::WR1_W-1:0]     wr1_q;
  logic [31:0]                   rd0_q;
  logic [sat_pkg::WR1_W-1:0]     rd1_q;
  logic                          mk_pend_q;
  logic                          rd_pend_q;
  logic                          mk_req_q;
  logic [sat_pkg::ENT_W-1:0]     mk_entry_q;
  logic                          rd_req_q;
  logic                          rd_first_q;
  logic [31:0]                   rdata_q;
  logic                          ack_q;

  sat_tbl_if tif ();

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // Only a 0-to-1 transition of a command bit starts work; writing zero just clears it.
  wire logic wr_cmd   = csr_wr && (csr_addr == sat_pkg::REG_CMD);
  wire logic wr_w0    = csr_wr && (csr_addr == sat_pkg::REG_WR0);
  wire logic wr_w1    = csr_wr && (csr_addr == sat_pkg::REG_WR1);
  wire logic mk_go    = wr_cmd && csr_wdata[sat_pkg::CMD_MAKE_BIT] &&
                        !cmd_q[sat_pkg::CMD_MAKE_BIT] && !mk_pend_q;
  wire logic first_go = csr_wdata[sat_pkg::CMD_FIRST_BIT] && !cmd_q[sat_pkg::CMD_FIRST_BIT];
  wire logic next_go  = csr_wdata[sat_pkg::CMD_NEXT_BIT] && !cmd_q[sat_pkg::CMD_NEXT_BIT];
  wire logic rd_go    = wr_cmd && (first_go || next_go) && !rd_pend_q;
  wire logic [31:0] sts_w = {30'h0000_0000, rd_pend_q, mk_pend_q};

  // Read data selection; unmapped numbers read as zero.
  wire logic [31:0] rsel_w =
    (csr_addr == sat_pkg::REG_CMD)     ? {29'h0000_0000, cmd_q} :
    (csr_addr == sat_pkg::REG_WR0)     ? wr0_q :
    (csr_addr == sat_pkg::REG_WR1)     ? {7'h00, wr1_q} :
    (csr_addr == sat_pkg::REG_RD0)     ? rd0_q :
    (csr_addr == sat_pkg::REG_RD1)     ? {7'h00, rd1_q} :
    (csr_addr == sat_pkg::REG_CMD_STS) ? sts_w : 32'h0000_0000;

  assign tif.mk_req   = mk_req_q;
  assign tif.mk_entry = mk_entry_q;
  assign tif.rd_req   = rd_req_q;
  assign tif.rd_first = rd_first_q;
  assign tif.ln_valid = learn_valid;
  assign tif.ln_mac   = learn_mac;
  assign tif.ln_port  = learn_port;
  assign csr_rdata    = rdata_q;
  assign csr_ack      = ack_q;

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  // Data words hold what software wrote; WR1 keeps only the low 25 bits.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      cmd_q <= 3'h0;
      wr0_q <= sat_pkg::WR0_RESET;
      wr1_q <= sat_pkg::WR1_RESET;
    end else begin
      if (wr_cmd) cmd_q <= csr_wdata[2:0];
      if (wr_w0) wr0_q <= csr_wdata;
      if (wr_w1) wr1_q <= csr_wdata[sat_pkg::WR1_W-1:0];
    end
  end

  // Make request; the entry is captured once so later data writes cannot tear it.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      mk_req_q   <= 1'b0;
      mk_pend_q  <= 1'b0;
      mk_entry_q <= '0;
    end else begin
      mk_req_q  <= mk_go;
      mk_pend_q <= mk_go || (mk_pend_q && !tif.mk_done);
      if (mk_go) mk_entry_q <= {wr1_q, wr0_q};
    end
  end

  // Read request and read words; the words change only on a read answer.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rd_req_q   <= 1'b0;
      rd_first_q <= 1'b0;
      rd_pend_q  <= 1'b0;
      rd0_q      <= 32'h0000_0000;
      rd1_q      <= '0;
    end else begin
      rd_req_q  <= rd_go;
      rd_pend_q <= rd_go || (rd_pend_q && !tif.rd_done);
      if (rd_go) rd_first_q <= first_go;
      if (tif.rd_done) begin
        rd0_q <= tif.rd_entry[31:0];
        rd1_q <= tif.rd_entry[sat_pkg::ENT_W-1:32];
      end
    end
  end

  // Register read answer, one cycle after the strobe.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rdata_q <= 32'h0000_0000;
      ack_q   <= 1'b0;
    end else begin
      ack_q <= csr_rd || csr_wr;
      if (csr_rd) rdata_q <= rsel_w;
    end
  end

  sat_table #(
    .DEPTH      (DEPTH),
    .AGE_CYCLES (AGE_CYCLES)
  ) u_table (
    .core_clk (core_clk),
    .nrst     (nrst),
    .tb       (tif)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  sequence s_make_go;
    wr_cmd && csr_wdata[sat_pkg::CMD_MAKE_BIT] && !cmd_q[sat_pkg::CMD_MAKE_BIT] && !mk_pend_q;
  endsequence
  sequence s_make_run;
    mk_pend_q [*2] ##1 !mk_pend_q;
  endsequence

  AST_MAKE_START: assert property (s_make_go |=> mk_req_q && mk_pend_q)
    else $error("Make command did not start.");
  AST_MAKE_PAYLOAD: assert property (mk_req_q |-> mk_entry_q == $past({wr1_q, wr0_q}))
    else $error("Make entry differs from the write words.");
  AST_MAKE_FINISH: assert property (s_make_go |=> s_make_run)
    else $error("Make status did not clear two cycles after start.");
  AST_ZERO_NOOP: assert property (wr_cmd && (csr_wdata[2:0] == 3'h0) |=>
    !mk_req_q && !rd_req_q)
    else $error("Writing zero started a table command.");
  AST_FIRST_RESTART: assert property (rd_go && first_go |=> rd_req_q && rd_first_q)
    else $error("Get-first did not request a restart.");
  AST_READ_LOAD: assert property (rd_go ##1 rd_req_q ##1 tif.rd_done |=>
    rd0_q == $past(tif.rd_entry[31:0]))
    else $error("Read word zero not loaded from the table answer.");
  AST_READ_STABLE: assert property (!tif.rd_done |=> $stable(rd0_q) && $stable(rd1_q))
    else $error("Read words changed without a read command.");
  AST_WR0_HOLD: assert property (wr_w0 |=> wr0_q == $past(csr_wdata))
    else $error("Write word zero did not take the written value.");
endmodule : sat_top

// *** testbench/tb_top.sv ***
// Self-checking bench for the address table register front end.
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin \
  $display("wrong value %s expected %0h seen %0h", nm, exp, got); mismatches++; end end
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // Aging is shortened so that one removal fits into a short run.
  localparam longint AGE = 2000;
  // Clock and reset.
  logic                       core_clk = 1'b0;
  logic                       nrst     = 1'b0;
  // Register port.
  logic [15:0]                csr_addr  = 16'h0000;
  logic                       csr_wr    = 1'b0;
  logic                       csr_rd    = 1'b0;
  logic [31:0]                csr_wdata = 32'h0000_0000;
  logic [31:0]                csr_rdata;
  logic                       csr_ack;
  // Learning events.
  logic                       learn_valid = 1'b0;
  logic [sat_pkg::MAC_W-1:0]  learn_mac   = 48'h0000_0000_0000;
  logic [sat_pkg::PORT_W-1:0] learn_port  = 3'h0;
  int                         mismatches   = 0;
  int                         total_checks = 0;
  logic [31:0]                seed = 32'h0001_5793;
  logic [sat_pkg::ENT_W-1:0]  model [logic [47:0]];

  sat_top #(.DEPTH(sat_pkg::TABLE_DEPTH), .AGE_CYCLES(AGE)) u_dut (
    .core_clk(core_clk), .nrst(nrst), .csr_addr(csr_addr), .csr_wr(csr_wr),
    .csr_rd(csr_rd), .csr_wdata(csr_wdata), .csr_rdata(csr_rdata), .csr_ack(csr_ack),
    .learn_valid(learn_valid), .learn_mac(learn_mac), .learn_port(learn_port));

  always #4 core_clk = ~core_clk;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Xorshift keeps the random stream repeatable across simulators.
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // A learned entry is valid, ages normally, is not static and has no filter or priority.
  function automatic logic [sat_pkg::ENT_W-1:0] learned_entry(input logic [47:0] m,
                                                               input logic [2:0]  p);
    return {1'b1, 1'b1, 1'b0, 3'h0, p, m};
  endfunction

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Strobes are one-cycle pulses; the answer is due one cycle after the strobe edge.
  task automatic csr_write(input logic [15:0] a, input logic [31:0] d);
    @(posedge core_clk); #1;
    csr_addr = a; csr_wdata = d; csr_wr = 1'b1;
    @(posedge core_clk); #1;
    csr_wr = 1'b0;
    `CHK("write ack", 1'b1, csr_ack)
  endtask

  task automatic csr_read(input logic [15:0] a, output logic [31:0] d);
    @(posedge core_clk); #1;
    csr_addr = a; csr_rd = 1'b1;
    @(posedge core_clk); #1;
    csr_rd = 1'b0;
    d = csr_rdata;
    `CHK("read ack", 1'b1, csr_ack)
  endtask

  // Issues one command, waits for the pending flags to drop, then clears it.
  task automatic run_cmd(input logic [31:0] c);
    logic [31:0] s;
    int          i;
    csr_write(sat_pkg::REG_CMD, c);
    for (i = 0; i < 40; i++) begin
      csr_read(sat_pkg::REG_CMD_STS, s);
      if (s[1:0] == 2'b00) break;
    end
    if (i == 40) begin
      mismatches++;
      tally_and_finish();
    end
    csr_write(sat_pkg::REG_CMD, 32'h0000_0000);
  endtask

  task automatic make(input logic [31:0] w0, input logic [31:0] w1);
    csr_write(sat_pkg::REG_WR0, w0);
    csr_write(sat_pkg::REG_WR1, w1);
    run_cmd(32'h0000_0004);
    if (w1[24]) model[{w1[15:0], w0}] = {w1[24:0], w0};
    else model.delete({w1[15:0], w0});
  endtask

  // Walks the table and compares every entry with the bench copy, in any order.
  task automatic walk_check();
    logic [31:0] r0, r1;
    int          n;
    n = 0;
    run_cmd(32'h0000_0002);
    repeat (70) begin
      csr_read(sat_pkg::REG_RD0, r0);
      csr_read(sat_pkg::REG_RD1, r1);
      if (r1[24] == 1'b0) break;
      if (model.exists({r1[15:0], r0})) begin
        `CHK("entry", model[{r1[15:0], r0}], {r1[24:0], r0})
      end else begin
        `CHK("unknown entry", 48'h0, {r1[15:0], r0})
      end
      n++;
      run_cmd(32'h0000_0001);
    end
    `CHK("entry count", model.num(), n)
  endtask

  task automatic learn(input logic [47:0] m, input logic [2:0] p);
    @(posedge core_clk); #1;
    learn_valid = 1'b1; learn_mac = m; learn_port = p;
    @(posedge core_clk); #1;
    learn_valid = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [15:0] regs [7];
    logic [31:0] d, w0, w1, keep;
    logic [47:0] lm;
    regs = '{sat_pkg::REG_CMD, sat_pkg::REG_WR0, sat_pkg::REG_WR1, sat_pkg::REG_RD0,
             sat_pkg::REG_RD1, sat_pkg::REG_CMD_STS, 16'h1803};
    repeat (2) @(posedge core_clk);
    #1;
    nrst = 1'b1;
    // Reset values, an unmapped place and the read-only status.
    foreach (regs[i]) begin
      csr_read(regs[i], d);
      `CHK("reset value", 32'h0000_0000, d)
    end
    csr_write(sat_pkg::REG_CMD_STS, 32'hFFFF_FFFF);
    csr_read(sat_pkg::REG_CMD_STS, d);
    `CHK("status read only", 32'h0000_0000, d)
    // Zero command bits start nothing and reserved bits read zero.
    csr_write(sat_pkg::REG_CMD, 32'hFFFF_FFF8);
    csr_read(sat_pkg::REG_CMD_STS, d);
    `CHK("no command started", 32'h0000_0000, d)
    csr_read(sat_pkg::REG_CMD, d);
    `CHK("command reserved", 32'h0000_0000, d)
    walk_check();
    // Random static entries, with the multicast bit and attributes spread.
    repeat (6) begin
      w0 = rnd();
      w1 = {7'h00, 1'b1, 1'(rnd()), 1'b1, 3'(rnd()), 3'(rnd() % 3), 16'(rnd())};
      make(w0, w1);
    end
    make(32'h0000_0001, 32'h0160_0000 | 32'h0000_ABCD);
    walk_check();
    // Read words stay put while other registers change; a live entry makes the check bite.
    run_cmd(32'h0000_0002);
    csr_read(sat_pkg::REG_RD0, keep);
    csr_write(sat_pkg::REG_WR0, rnd());
    csr_write(sat_pkg::REG_CMD, 32'h0000_0000);
    csr_read(sat_pkg::REG_RD0, d);
    `CHK("read word stable", keep, d)
    // Change an existing entry, then delete it with valid and static cleared.
    make(32'h0000_0001, 32'h0152_ABCD);
    walk_check();
    make(32'h0000_0001, 32'h0000_ABCD);
    walk_check();
    // Learning adds an aging entry and must not touch a static one.
    lm = {16'(rnd()), rnd()} & 48'hFFFF_FFFF_FFFE;
    learn(lm, 3'h2);
    model[lm] = learned_entry(lm, 3'h2);
    w1 = 32'h0142_0000 | 32'h0000_5A5A;
    make(32'h1234_5678, w1);
    learn({16'h5A5A, 32'h1234_5678}, 3'h1);
    walk_check();
    // The learned entry ages out within two periods; static ones stay.
    repeat (2 * AGE + 20) @(posedge core_clk);
    model.delete(lm);
    walk_check();
    tally_and_finish();
  end

  // A hang is cut short and counted.
  initial begin
    repeat (100000) @(posedge core_clk);
    mismatches++;
    tally_and_finish();
  end
endmodule // tb_top
